// ==== rtl/host_port_fifo_ctrl.sv ====
// host port fifos with write bursting, flush control, soft reset and suspend halt
`timescale 1ns/1ns
`default_nettype none
module host_port_fifo_ctrl (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [hpi_fifo_pkg::AV_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [hpi_fifo_pkg::DATA_W-1:0] AVS_WRITEDATA,
  output logic [hpi_fifo_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic HOST_STROBE_N,
  input wire logic HOST_RNW,
  input wire logic [1:0] HOST_CNTL,
  input wire logic HOST_ADDR_SEL_RD,
  input wire logic [hpi_fifo_pkg::DATA_W-1:0] HOST_WDATA,
  output logic [hpi_fifo_pkg::DATA_W-1:0] HOST_RDATA,
  output logic HOST_READY_N,
  input wire logic EMU_SUSPEND,
  output logic DMA_WR_REQ,
  output logic [hpi_fifo_pkg::DATA_W-1:0] DMA_WR_ADDR,
  output logic [2:0] DMA_WR_LEN,
  input wire logic DMA_WR_GNT,
  output logic DMA_WR_VALID,
  output logic [hpi_fifo_pkg::DATA_W-1:0] DMA_WR_DATA,
  output logic DMA_RD_REQ,
  output logic [hpi_fifo_pkg::DATA_W-1:0] DMA_RD_ADDR,
  output logic [2:0] DMA_RD_LEN,
  input wire logic DMA_RD_GNT,
  input wire logic DMA_RD_VALID,
  input wire logic [hpi_fifo_pkg::DATA_W-1:0] DMA_RD_DATA
);
  import hpi_fifo_pkg::*;

  typedef struct packed {
    // two-stage synchronisers for host pins and suspend
    logic strb_m;
    logic strb_s;
    logic rnw_m;
    logic rnw_s;
    logic [1:0] cntl_m;
    logic [1:0] cntl_s;
    logic asel_m;
    logic asel_s;
    logic emu_m;
    logic emu_s;
    logic [DATA_W-1:0] hwdata_m;
    logic [DATA_W-1:0] hwdata_s;
    // host cycle handling
    host_state_t hst;
    logic hw_abort;
    logic [1:0] armed;
    logic cyc_fl;
    logic cyc_req;
    logic ready_n;
    logic [DATA_W-1:0] hrdata;
    // software registers
    logic dual;
    logic srst_bit;
    logic srst_busy;
    logic emu_free;
    logic emu_soft;
    logic av_wait;
    logic [DATA_W-1:0] av_rdata;
    // fifos
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] wf;
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] rf;
    logic [PTR_W-1:0] wwp;
    logic [PTR_W-1:0] wrp;
    logic [PTR_W-1:0] rwp;
    logic [PTR_W-1:0] rrp;
    logic wflush;
    logic rflush;
    logic wburst_en;
    logic rpre_en;
    logic rsingle;
    logic [8:0] wtimer;
    // dma engines
    dma_state_t wst;
    dma_state_t rst;
    logic [2:0] wlen;
    logic [2:0] rlen;
    logic [DATA_W-1:0] wdma_addr;
    logic [DATA_W-1:0] rdma_addr;
    logic wr_req;
    logic [DATA_W-1:0] wr_addr;
    logic [2:0] wr_len;
    logic wr_valid;
    logic [DATA_W-1:0] wr_data;
    logic rd_req;
    logic [DATA_W-1:0] rd_addr;
    logic [2:0] rd_len;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [PTR_W-1:0] fifo_count(input logic [PTR_W-1:0] wp,
                                                  input logic [PTR_W-1:0] rp);
    fifo_count = wp - rp;
  endfunction

  logic [PTR_W-1:0] wcnt;
  logic [PTR_W-1:0] rcnt;
  logic halted;
  logic srst_cond;
  logic dma_idle;
  logic sel_r;
  logic sel_w;
  logic [2:0] wstart_len;
  logic [2:0] rstart_len;

  assign wcnt = fifo_count(q.wwp, q.wrp);
  assign rcnt = fifo_count(q.rwp, q.rrp);
  assign halted = q.emu_s & ~q.emu_free & q.emu_soft;
  assign srst_cond = q.srst_bit | q.srst_busy;
  assign dma_idle = (q.wst == D_IDLE) && (q.rst == D_IDLE);
  // in shared-address mode every flush reaches both fifos
  assign sel_r = q.asel_s | ~q.dual;
  assign sel_w = ~q.asel_s | ~q.dual;

  always_comb begin
    d = q;
    wstart_len = 3'h0;
    rstart_len = 3'h0;

    //--------------------------------------------------------------------------
    // synchronisers
    //--------------------------------------------------------------------------
    d.strb_m = HOST_STROBE_N;
    d.strb_s = q.strb_m;
    d.rnw_m = HOST_RNW;
    d.rnw_s = q.rnw_m;
    d.cntl_m = HOST_CNTL;
    d.cntl_s = q.cntl_m;
    d.asel_m = HOST_ADDR_SEL_RD;
    d.asel_s = q.asel_m;
    d.emu_m = EMU_SUSPEND;
    d.emu_s = q.emu_m;
    d.hwdata_m = HOST_WDATA;
    d.hwdata_s = q.hwdata_m;

    //--------------------------------------------------------------------------
    // register bus: one wait state, then the access completes
    //--------------------------------------------------------------------------
    d.av_wait = 1'b1;
    if ((AVS_READ || AVS_WRITE) && q.av_wait) begin
      d.av_wait = 1'b0;
      d.av_rdata = '0;
      case (AVS_ADDRESS)
        OFF_PORT_CTRL: begin
          d.av_rdata[CTRL_DUAL_BIT] = q.dual;
          d.av_rdata[CTRL_SRST_BIT] = q.srst_bit & ~q.srst_busy;
          d.av_rdata[CTRL_READY_BIT] = q.ready_n;
        end
        OFF_EMU_MGMT: begin
          d.av_rdata[EMU_FREE_BIT] = q.emu_free;
          d.av_rdata[EMU_SOFT_BIT] = q.emu_soft;
        end
        OFF_STATUS: begin
          d.av_rdata[STAT_WCNT_LSB +: PTR_W] = wcnt;
          d.av_rdata[STAT_RCNT_LSB +: PTR_W] = rcnt;
          d.av_rdata[STAT_WFLUSH_BIT] = q.wflush;
          d.av_rdata[STAT_RFLUSH_BIT] = q.rflush;
          d.av_rdata[STAT_HALT_BIT] = halted;
        end
        default: d.av_rdata = '0;
      endcase
    end
    if (AVS_WRITE && !q.av_wait) begin
      case (AVS_ADDRESS)
        OFF_PORT_CTRL: begin
          d.dual = AVS_WRITEDATA[CTRL_DUAL_BIT];
          d.srst_bit = AVS_WRITEDATA[CTRL_SRST_BIT];
          // a 0 write drops the level but the started reset runs on
          if (AVS_WRITEDATA[CTRL_SRST_BIT]) begin
            d.srst_busy = 1'b1;
          end
        end
        OFF_EMU_MGMT: begin
          d.emu_free = AVS_WRITEDATA[EMU_FREE_BIT];
          d.emu_soft = AVS_WRITEDATA[EMU_SOFT_BIT];
        end
        default: begin
        end
      endcase
    end

    //--------------------------------------------------------------------------
    // write dma engine
    //--------------------------------------------------------------------------
    d.wr_valid = 1'b0;
    case (q.wst)
      D_IDLE: begin
        if (!halted && !srst_cond) begin
          if (wcnt >= BURST_WORDS && (q.wburst_en || q.wflush)) begin
            wstart_len = BURST_LEN;
          end else if (wcnt != '0 && (q.wflush || q.wtimer == WR_TIMEOUT_CYCLES)) begin
            wstart_len = wcnt[2:0];
          end
        end
        if (wstart_len != 3'h0) begin
          d.wr_req = 1'b1;
          d.wr_addr = q.wdma_addr;
          d.wr_len = wstart_len;
          d.wlen = wstart_len;
          d.wtimer = '0;
          d.wst = D_REQ;
        end else if (wcnt == '0) begin
          d.wtimer = '0;
        end else if (q.wtimer != WR_TIMEOUT_CYCLES) begin
          d.wtimer = q.wtimer + 9'h001;
        end
      end
      D_REQ: begin
        if (DMA_WR_GNT) begin
          d.wr_req = 1'b0;
          d.wst = D_XFER;
        end
      end
      D_XFER: begin
        d.wr_valid = 1'b1;
        d.wr_data = q.wf[q.wrp[2:0]];
        d.wrp = q.wrp + 4'h1;
        d.wlen = q.wlen - 3'h1;
        d.wdma_addr = q.wdma_addr + ADDR_STEP;
        if (q.wlen == SINGLE_LEN) begin
          d.wst = D_IDLE;
        end
      end
      default: d.wst = D_IDLE;
    endcase

    //--------------------------------------------------------------------------
    // read dma engine
    //--------------------------------------------------------------------------
    case (q.rst)
      D_IDLE: begin
        if (!halted && !srst_cond && !q.rflush) begin
          if (q.rpre_en && rcnt <= BURST_WORDS) begin
            rstart_len = BURST_LEN;
          end else if (q.rsingle && rcnt == '0) begin
            rstart_len = SINGLE_LEN;
            d.rsingle = 1'b0;
          end
        end
        if (rstart_len != 3'h0) begin
          d.rd_req = 1'b1;
          d.rd_addr = q.rdma_addr;
          d.rd_len = rstart_len;
          d.rlen = rstart_len;
          d.rst = D_REQ;
        end
      end
      D_REQ: begin
        if (DMA_RD_GNT) begin
          d.rd_req = 1'b0;
          d.rst = D_XFER;
        end
      end
      D_XFER: begin
        if (DMA_RD_VALID) begin
          d.rf[q.rwp[2:0]] = DMA_RD_DATA;
          d.rwp = q.rwp + 4'h1;
          d.rlen = q.rlen - 3'h1;
          d.rdma_addr = q.rdma_addr + ADDR_STEP;
          if (q.rlen == SINGLE_LEN) begin
            d.rst = D_IDLE;
          end
        end
      end
      default: d.rst = D_IDLE;
    endcase

    //--------------------------------------------------------------------------
    // flush completion: only once the engine holds no request or burst
    //--------------------------------------------------------------------------
    if (q.wflush && wcnt == '0 && q.wst == D_IDLE) begin
      d.wflush = 1'b0;
      d.wburst_en = 1'b0;
    end
    if (q.rflush && q.rst == D_IDLE) begin
      d.rrp = '0;
      d.rwp = '0;
      d.rflush = 1'b0;
      d.rpre_en = 1'b0;
    end

    //--------------------------------------------------------------------------
    // host cycles
    //--------------------------------------------------------------------------
    d.armed = {q.armed[0], 1'b1};
    if (q.strb_s && q.armed[1]) begin
      d.hw_abort = 1'b0;
    end
    case (q.hst)
      H_IDLE: begin
        d.cyc_fl = 1'b0;
        d.cyc_req = 1'b0;
        if (!q.strb_s) begin
          if (q.hw_abort) begin
            d.hst = H_DONE;
          end else if (!srst_cond) begin
            d.hst = H_SERVE;
          end
        end
      end
      H_SERVE: begin
        if (srst_cond) begin
          // the interrupted cycle is released only after dma has drained
          if (dma_idle) begin
            d.hst = H_DONE;
          end
        end else begin
          case (q.cntl_s)
            CNTL_ADDR: begin
              if (q.rnw_s) begin
                d.hrdata = q.asel_s ? q.rdma_addr : q.wdma_addr;
                d.hst = H_DONE;
              end else if (!q.cyc_fl) begin
                d.wflush = q.wflush | sel_w;
                d.rflush = q.rflush | sel_r;
                d.cyc_fl = 1'b1;
              end else if (!q.wflush && !q.rflush) begin
                if (sel_w) begin
                  d.wdma_addr = q.hwdata_s;
                end
                if (sel_r) begin
                  d.rdma_addr = q.hwdata_s;
                end
                d.hst = H_DONE;
              end
            end
            CNTL_DATA_INC: begin
              if (!q.cyc_fl && !q.dual && (q.rnw_s ? wcnt : rcnt) != '0) begin
                d.wflush = 1'b1;
                d.rflush = 1'b1;
                d.cyc_fl = 1'b1;
              end else if (q.wflush || q.rflush) begin
                d.cyc_fl = 1'b1;
              end else if (q.rnw_s) begin
                if (rcnt != '0) begin
                  d.hrdata = q.rf[q.rrp[2:0]];
                  d.rrp = q.rrp + 4'h1;
                  d.hst = H_DONE;
                end else begin
                  d.rpre_en = 1'b1;
                end
              end else if (wcnt != FIFO_FULL) begin
                d.wf[q.wwp[2:0]] = q.hwdata_s;
                d.wwp = q.wwp + 4'h1;
                d.wtimer = '0;
                d.wburst_en = 1'b1;
                d.hst = H_DONE;
              end
            end
            CNTL_DATA_FIX: begin
              if (!q.cyc_fl) begin
                d.rflush = q.rflush | (q.rnw_s | ~q.dual);
                d.wflush = q.wflush | (~q.rnw_s | ~q.dual);
                d.rpre_en = q.rpre_en & ~q.rnw_s;
                d.cyc_fl = 1'b1;
              end else if (q.wflush || q.rflush) begin
                d.cyc_fl = 1'b1;
              end else if (q.rnw_s) begin
                if (rcnt != '0) begin
                  d.hrdata = q.rf[q.rrp[2:0]];
                  d.rrp = q.rrp + 4'h1;
                  d.hst = H_DONE;
                end else if (!q.cyc_req) begin
                  d.rsingle = 1'b1;
                  d.cyc_req = 1'b1;
                end
              end else if (wcnt != FIFO_FULL) begin
                // one word, pushed straight out by its own flush
                d.wf[q.wwp[2:0]] = q.hwdata_s;
                d.wwp = q.wwp + 4'h1;
                d.wtimer = '0;
                d.wburst_en = 1'b0;
                d.wflush = 1'b1;
                d.hst = H_DONE;
              end
            end
            default: d.hst = H_DONE;
          endcase
        end
      end
      H_DONE: begin
        if (q.strb_s) begin
          d.hst = H_IDLE;
        end
      end
      default: d.hst = H_IDLE;
    endcase

    //--------------------------------------------------------------------------
    // soft reset: fifos cleared once no dma is outstanding
    //--------------------------------------------------------------------------
    if (srst_cond && dma_idle) begin
      d.wwp = '0;
      d.wrp = '0;
      d.rwp = '0;
      d.rrp = '0;
      d.wflush = 1'b0;
      d.rflush = 1'b0;
      d.wburst_en = 1'b0;
      d.rpre_en = 1'b0;
      d.rsingle = 1'b0;
      d.wtimer = '0;
      d.srst_busy = 1'b0;
    end

    // ready is low only while the host cycle is being completed
    d.ready_n = (d.hst != H_DONE);
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.strb_m <= 1'b1;
      q.strb_s <= 1'b1;
      q.hst <= H_IDLE;
      q.hw_abort <= 1'b1;
      q.ready_n <= 1'b1;
      q.dual <= DUAL_RST;
      q.srst_bit <= SRST_RST;
      q.emu_free <= EMU_FREE_RST;
      q.emu_soft <= EMU_SOFT_RST;
      q.av_wait <= 1'b1;
      q.wst <= D_IDLE;
      q.rst <= D_IDLE;
    end else begin
      q <= d;
    end
  end

  assign AVS_READDATA = q.av_rdata;
  assign AVS_WAITREQUEST = q.av_wait;
  assign HOST_RDATA = q.hrdata;
  assign HOST_READY_N = q.ready_n;
  assign DMA_WR_REQ = q.wr_req;
  assign DMA_WR_ADDR = q.wr_addr;
  assign DMA_WR_LEN = q.wr_len;
  assign DMA_WR_VALID = q.wr_valid;
  assign DMA_WR_DATA = q.wr_data;
  assign DMA_RD_REQ = q.rd_req;
  assign DMA_RD_ADDR = q.rd_addr;
  assign DMA_RD_LEN = q.rd_len;

endmodule // host_port_fifo_ctrl
`default_nettype wire

// ==== rtl/hpi_fifo_pkg.sv ====
// constants, state codes and register map of the host port fifo flush control block
//------------------------------------------------------------------------------
// Overview of operation
// - host write of the write address register flushes the write fifo to memory.
// - after a write flush only autoincrement writes burst; wait for four words.
// - four or more queued words trigger a 4-word memory burst, repeatedly.
// - eight queued words hold the host off until a slot frees.
// - time-out with under four words drains by 3-, 2- or 1-word write.
// - write time-out is 256 clocks, restarted by each new word.
// - fixed-address data write flushes, writes one word, and stops bursting.
// - read flush lets pending accesses and requested dma finish, then drops data.
// - write flush lets pending work finish, then writes out all posted words.
// - data cycles arriving during a flush are stalled until it ends.
// - read address write and fixed-address data read flush the read fifo.
// - shared-address mode makes any flush trigger flush both fifos.
// - shared-address mode flushes both on cross-direction autoincrement access.
// - dual-address mode does no cross-direction flushing.
// - hardware or soft reset clears both fifos and their logic.
// - a host cycle active at reset is completed with ready low, then high.
// - during reset with host idle, fifos stay in reset and ready stays high.
// - soft reset during a host cycle waits for dma before releasing it.
// - soft reset bit reads 0 until done; writing 0 cannot abort; fifos only.
// - hardware reset returns all registers to defaults.
// - halting suspend stops dma after current work, only if not free and soft.
// - while halted host cycles needing service stall; resume services fifos.
// - each fifo holds eight 32-bit words.
// - fixed-address data read flushes and fetches exactly one word, no prefetch.
//------------------------------------------------------------------------------
package hpi_fifo_pkg;

  localparam int DATA_W = 32;
  localparam int AV_ADDR_W = 4;
  localparam int PTR_W = 4;
  localparam int FIFO_DEPTH = 8;

  localparam logic [PTR_W-1:0] FIFO_FULL = 4'h8;
  localparam logic [PTR_W-1:0] BURST_WORDS = 4'h4;
  localparam logic [2:0] BURST_LEN = 3'h4;
  localparam logic [2:0] SINGLE_LEN = 3'h1;
  localparam logic [DATA_W-1:0] ADDR_STEP = 32'h0000_0004;

  // write time-out, in internal clock cycles
  localparam logic [8:0] WR_TIMEOUT_CYCLES = 9'h100;

  // register byte offsets
  localparam logic [AV_ADDR_W-1:0] OFF_PORT_CTRL = 4'h0;
  localparam logic [AV_ADDR_W-1:0] OFF_EMU_MGMT = 4'h4;
  localparam logic [AV_ADDR_W-1:0] OFF_STATUS = 4'h8;

  // port_control_reg fields
  localparam int CTRL_DUAL_BIT = 9;
  localparam int CTRL_SRST_BIT = 7;
  localparam int CTRL_READY_BIT = 3;
  // emu_power_mgmt_reg fields
  localparam int EMU_FREE_BIT = 0;
  localparam int EMU_SOFT_BIT = 1;
  // status register fields
  localparam int STAT_WCNT_LSB = 0;
  localparam int STAT_RCNT_LSB = 8;
  localparam int STAT_WFLUSH_BIT = 16;
  localparam int STAT_RFLUSH_BIT = 17;
  localparam int STAT_HALT_BIT = 18;

  // reset values
  localparam logic DUAL_RST = 1'b0;
  localparam logic SRST_RST = 1'b0;
  localparam logic EMU_FREE_RST = 1'b0;
  localparam logic EMU_SOFT_RST = 1'b0;

  // host cycle types on the control pins
  localparam logic [1:0] CNTL_CTRL = 2'h0;
  localparam logic [1:0] CNTL_DATA_INC = 2'h1;
  localparam logic [1:0] CNTL_ADDR = 2'h2;
  localparam logic [1:0] CNTL_DATA_FIX = 2'h3;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SERVE = 3'b010,
    H_DONE = 3'b100
  } host_state_t;

  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_REQ = 3'b010,
    D_XFER = 3'b100
  } dma_state_t;

endpackage

// ==== testbench/hpi_fifo_monitor.sv ====
// concurrent checks on the ports of the host port fifo block
`timescale 1ns/1ns
`default_nettype none
module hpi_fifo_monitor
  import hpi_fifo_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic HOST_STROBE_N,
  input wire logic HOST_READY_N,
  input wire logic DMA_WR_REQ,
  input wire logic [DATA_W-1:0] DMA_WR_ADDR,
  input wire logic [2:0] DMA_WR_LEN,
  input wire logic DMA_WR_GNT,
  input wire logic DMA_WR_VALID,
  input wire logic DMA_RD_REQ,
  input wire logic [2:0] DMA_RD_LEN,
  input wire logic DMA_RD_GNT
);
  // ----------
  // burst word counter
  // ----------
  logic [2:0] len_q;
  logic [2:0] cnt_q;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      len_q <= 3'h0;
      cnt_q <= 3'h0;
    end else if (DMA_WR_REQ && DMA_WR_GNT) begin
      len_q <= DMA_WR_LEN;
      cnt_q <= 3'h0;
    end else if (DMA_WR_VALID) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // ----------
  // assertions
  // ----------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  chk_rst_idle: assert property ($rose(RESETN) |-> AVS_WAITREQUEST && HOST_READY_N)
    else $error("not idle after reset");
  chk_ready_hold: assert property (!HOST_READY_N && !HOST_STROBE_N |=> !HOST_READY_N)
    else $error("ready withdrawn");
  chk_ready_rel: assert property (HOST_STROBE_N [*6] |-> HOST_READY_N)
    else $error("ready low with host idle");
  chk_avs_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("register not answered");
  chk_wr_hold: assert property (DMA_WR_REQ && !DMA_WR_GNT
    |=> DMA_WR_REQ && $stable(DMA_WR_ADDR) && $stable(DMA_WR_LEN))
    else $error("write request dropped");
  chk_rd_hold: assert property (DMA_RD_REQ && !DMA_RD_GNT |=> DMA_RD_REQ && $stable(DMA_RD_LEN))
    else $error("read request dropped");
  chk_burst_start: assert property (DMA_WR_REQ && DMA_WR_GNT |-> ##2 DMA_WR_VALID)
    else $error("burst data late");
  chk_burst_count: assert property ($fell(DMA_WR_VALID) |-> cnt_q == len_q)
    else $error("burst count wrong");
  chk_wr_len: assert property (DMA_WR_REQ |-> DMA_WR_LEN inside {[3'h1:3'h4]})
    else $error("bad write length");
  chk_rd_len: assert property (DMA_RD_REQ |-> DMA_RD_LEN == 3'h1 || DMA_RD_LEN == 3'h4)
    else $error("bad read length");
  chk_no_overlap: assert property (DMA_WR_VALID |-> !DMA_WR_REQ)
    else $error("request during burst");
  cover property (DMA_WR_REQ && DMA_WR_GNT && DMA_WR_LEN == 3'h4);
  cover property (DMA_WR_REQ && DMA_WR_GNT && DMA_WR_LEN == 3'h3);
  cover property (DMA_WR_REQ && DMA_WR_GNT && DMA_WR_LEN == 3'h1);
  cover property (DMA_RD_REQ && DMA_RD_GNT);
endmodule // hpi_fifo_monitor
bind host_port_fifo_ctrl hpi_fifo_monitor u_mon (.CLOCK(CLOCK), .RESETN(RESETN),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .HOST_STROBE_N(HOST_STROBE_N), .HOST_READY_N(HOST_READY_N), .DMA_WR_REQ(DMA_WR_REQ),
  .DMA_WR_ADDR(DMA_WR_ADDR), .DMA_WR_LEN(DMA_WR_LEN), .DMA_WR_GNT(DMA_WR_GNT),
  .DMA_WR_VALID(DMA_WR_VALID), .DMA_RD_REQ(DMA_RD_REQ), .DMA_RD_LEN(DMA_RD_LEN),
  .DMA_RD_GNT(DMA_RD_GNT));
`default_nettype wire

// ==== testbench/hpi_mem_model.sv ====
// processor memory side: grants dma bursts and returns read words
`timescale 1ns/1ns
`default_nettype none
module hpi_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic wr_req,
  output logic wr_gnt,
  input wire logic rd_req,
  input wire logic [2:0] rd_len,
  output logic rd_gnt,
  output logic rd_valid,
  output logic [31:0] rd_data
);
  logic [2:0] left_q;
  logic [31:0] word_q;
  // hold makes the far side slow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_gnt <= 1'b0;
      rd_gnt <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
      left_q <= 3'h0;
      word_q <= 32'hA000_0000;
    end else begin
      wr_gnt <= wr_req && !wr_gnt && !hold;
      rd_gnt <= rd_req && !rd_gnt && left_q == 3'h0 && !hold;
      if (rd_gnt) begin
        left_q <= rd_len;
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
      end else if (left_q != 3'h0 && !hold) begin
        rd_valid <= 1'b1;
        rd_data <= word_q;
        word_q <= word_q + 32'h1;
        left_q <= left_q - 3'h1;
      end else begin
        // no stale word between strobes
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
      end
    end
  end
endmodule // hpi_mem_model
`default_nettype wire

// ==== testbench/host_port_fifo_flush_control_tb.sv ====
// self-checking bench of the host port fifo block
`timescale 1ns/1ns
`default_nettype none
module host_port_fifo_flush_control_tb;
  import hpi_fifo_pkg::*;
  logic CLOCK = 1'b0, RESETN = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, HOST_STROBE_N = 1'b1;
  logic HOST_RNW = 1'b0, HOST_ADDR_SEL_RD = 1'b0, EMU_SUSPEND = 1'b0, hold = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic [1:0] HOST_CNTL = 2'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0, HOST_WDATA = 32'h0;
  logic [31:0] AVS_READDATA, HOST_RDATA, DMA_WR_ADDR, DMA_WR_DATA, DMA_RD_ADDR, DMA_RD_DATA;
  logic AVS_WAITREQUEST, HOST_READY_N, DMA_WR_REQ, DMA_WR_GNT, DMA_WR_VALID;
  logic DMA_RD_REQ, DMA_RD_GNT, DMA_RD_VALID;
  logic [2:0] DMA_WR_LEN, DMA_RD_LEN;
  int n_errors = 0, n_compared = 0, cyc = 0, t = 0;
  logic [31:0] rd, d_q[$], a_q[$], l_q[$], r_q[$];
  typedef struct {logic [3:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
  row_t rows [6] = '{'{4'h0, 1'b0, 32'h0, 32'h8}, '{4'h4, 1'b0, 32'h0, 32'h0},
    '{4'h8, 1'b0, 32'h0, 32'h0}, '{4'h4, 1'b1, 32'h3, 32'h3},
    '{4'h4, 1'b1, 32'h0, 32'h0}, '{4'hC, 1'b1, 32'hFFFF_FFFF, 32'h0}};

  host_port_fifo_ctrl u_dut (.*);
  hpi_mem_model u_mem (.clk(CLOCK), .rst_n(RESETN), .hold(hold), .wr_req(DMA_WR_REQ),
    .wr_gnt(DMA_WR_GNT), .rd_req(DMA_RD_REQ), .rd_len(DMA_RD_LEN), .rd_gnt(DMA_RD_GNT),
    .rd_valid(DMA_RD_VALID), .rd_data(DMA_RD_DATA));

  initial begin
    forever #5 CLOCK = ~CLOCK;
  end
  // ----------
  // tasks
  // ----------
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a; AVS_WRITE <= w; AVS_READ <= !w; AVS_WRITEDATA <= d;
    @(posedge CLOCK);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge CLOCK);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0; AVS_WRITE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic hc(input logic r, input logic [1:0] c, input logic [31:0] d);
    HOST_RNW <= r; HOST_CNTL <= c; HOST_WDATA <= d; HOST_STROBE_N <= 1'b0;
    @(posedge CLOCK);
    while (HOST_READY_N !== 1'b0) @(posedge CLOCK);
    rd = HOST_RDATA;
    HOST_STROBE_N <= 1'b1;
    while (HOST_READY_N !== 1'b1) @(posedge CLOCK);
  endtask
  task automatic wq(input int n);
    while (d_q.size() < n) @(posedge CLOCK);
  endtask
  task automatic rst();
    RESETN <= 1'b0;
    repeat (8) @(posedge CLOCK);
    cmp("ready_n in reset", 32'h1, {31'h0, HOST_READY_N});
    RESETN <= 1'b1;
    repeat (2) @(posedge CLOCK);
  endtask
  // ----------
  // memory side capture and watchdog
  // ----------
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (DMA_WR_REQ && DMA_WR_GNT) begin
      a_q.push_back(DMA_WR_ADDR);
      l_q.push_back({29'h0, DMA_WR_LEN});
    end
    if (DMA_WR_VALID) d_q.push_back(DMA_WR_DATA);
    if (DMA_RD_REQ && DMA_RD_GNT) r_q.push_back({29'h0, DMA_RD_LEN});
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    rst();
    foreach (rows[i]) begin
      if (rows[i].w) av(1'b1, rows[i].a, rows[i].d);
      av(1'b0, rows[i].a, 32'h0);
      cmp("register", rows[i].e, rd);
    end
    hc(1'b0, CNTL_ADDR, 32'h100);
    for (int i = 0; i < 3; i++) hc(1'b0, CNTL_DATA_INC, 32'hD0 + i);
    repeat (20) @(posedge CLOCK);
    cmp("early burst", 32'h0, l_q.size());
    hc(1'b0, CNTL_DATA_INC, 32'hD3);
    wq(4);
    cmp("burst len", 32'h4, l_q[0]);
    cmp("burst addr", 32'h100, a_q[0]);
    for (int i = 0; i < 4; i++) cmp("burst data", 32'hD0 + i, d_q[i]);
    for (int i = 0; i < 3; i++) hc(1'b0, CNTL_DATA_INC, 32'hE0 + i);
    t = cyc;
    // short of the time-out
    repeat (245) @(posedge CLOCK);
    cmp("early timeout", 32'h1, l_q.size());
    wq(7);
    cmp("timeout len", 32'h3, l_q[1]);
    cmp("timeout addr", 32'h110, a_q[1]);
    cmp("timeout bound", 32'h1, {31'h0, (cyc - t) < 300});
    hc(1'b0, CNTL_ADDR, 32'h120);
    hc(1'b0, CNTL_DATA_FIX, 32'hF1);
    wq(8);
    cmp("single len", 32'h1, l_q[2]);
    cmp("single data", 32'hF1, d_q[7]);
    hold <= 1'b1;
    hc(1'b0, CNTL_ADDR, 32'h200);
    for (int i = 0; i < 8; i++) hc(1'b0, CNTL_DATA_INC, 32'h20 + i);
    HOST_WDATA <= 32'h28; HOST_CNTL <= CNTL_DATA_INC; HOST_STROBE_N <= 1'b0;
    repeat (30) @(posedge CLOCK);
    cmp("full stall", 32'h1, {31'h0, HOST_READY_N});
    hold <= 1'b0;
    while (HOST_READY_N !== 1'b0) @(posedge CLOCK);
    HOST_STROBE_N <= 1'b1;
    wq(17);
    cmp("full drain order", 32'h20, d_q[8]);
    cmp("ninth word", 32'h28, d_q[16]);
    hc(1'b0, CNTL_ADDR, 32'h300);
    for (int i = 0; i < 3; i++) hc(1'b0, CNTL_DATA_INC, 32'h30 + i);
    av(1'b0, OFF_STATUS, 32'h0);
    cmp("queued count", 32'h3, {28'h0, rd[3:0]});
    // a 0 write must not cancel it
    av(1'b1, OFF_PORT_CTRL, 32'h280);
    av(1'b1, OFF_PORT_CTRL, 32'h200);
    repeat (10) @(posedge CLOCK);
    av(1'b0, OFF_STATUS, 32'h0);
    cmp("soft reset count", 32'h0, {28'h0, rd[3:0]});
    av(1'b0, OFF_PORT_CTRL, 32'h0);
    cmp("dual mode kept", 32'h1, {31'h0, rd[9]});
    repeat (300) @(posedge CLOCK);
    cmp("discarded", 32'd17, d_q.size());
    HOST_ADDR_SEL_RD <= 1'b1;
    hc(1'b0, CNTL_ADDR, 32'h500);
    hc(1'b1, CNTL_DATA_FIX, 32'h0);
    cmp("fixed read data", 32'hA000_0000, rd);
    cmp("fixed read len", 32'h1, r_q[0]);
    cmp("read addr", 32'h500, DMA_RD_ADDR);
    HOST_ADDR_SEL_RD <= 1'b0;
    av(1'b1, OFF_EMU_MGMT, 32'h2);
    EMU_SUSPEND <= 1'b1;
    hc(1'b0, CNTL_ADDR, 32'h400);
    for (int i = 0; i < 4; i++) hc(1'b0, CNTL_DATA_INC, 32'h40 + i);
    repeat (40) @(posedge CLOCK);
    cmp("halted bursts", 32'd17, d_q.size());
    EMU_SUSPEND <= 1'b0;
    wq(21);
    cmp("resumed burst", 32'h40, d_q[17]);
    rst();
    test_done();
  end
endmodule // host_port_fifo_flush_control_tb
`default_nettype wire
